/* hw/ssfp_defs.vh */
// Purpose: Shared constants of the synchronous serial framing port.
// Assumes: Included by bare name from the framing engine under hw/.
// Notes: Definitions only.
`ifndef SSFP_DEFS_VH
`define SSFP_DEFS_VH

// ----------------------------------------
// Frame formats
// ----------------------------------------
`define SSFP_FMT_PULSED 2'h0
`define SSFP_FMT_SPI 2'h1
`define SSFP_FMT_CMDRSP 2'h2

// ----------------------------------------
// Engine states
// ----------------------------------------
`define SSFP_ST_IDLE 3'h0
`define SSFP_ST_FPA 3'h1
`define SSFP_ST_FPB 3'h2
`define SSFP_ST_LEAD 3'h3
`define SSFP_ST_BITA 3'h4
`define SSFP_ST_BITB 3'h5
`define SSFP_ST_TAIL 3'h6

// ----------------------------------------
// Word layout and buffering
// ----------------------------------------
`define SSFP_WORD_W 16
`define SSFP_SIZE_MIN 4'h3
`define SSFP_SIZE_MAX 4'hF
`define SSFP_FIFO_DEPTH 8
`define SSFP_FIFO_AW 3

`endif

/* hw/ssfp_fifo.v */
// Purpose: Word FIFO between the user's transmit stream and the framing engine.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Ready and valid are registered; full and empty follow the true fill count.
`timescale 1ns/1ps
`default_nettype none

module ssfp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire ref_clk,
	input wire srst,
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output reg inReady,
	output wire [WIDTH-1:0] outData,
	output reg outValid,
	input wire outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	reg [AW:0] next_count;
	wire doWrite;
	wire doRead;

	assign doWrite = inValid & inReady;
	assign doRead = outValid & outReady;
	assign outData = mem[rdPtr];

	always @* begin
		next_count = count;
		if (doWrite && !doRead)
			next_count = count + {{AW{1'b0}}, 1'b1};
		else if (doRead && !doWrite)
			next_count = count - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge ref_clk) begin
		if (doWrite)
			mem[wrPtr] <= inData;
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			inReady <= 1'b0;
			outValid <= 1'b0;
		end else begin
			if (doWrite)
				wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + {{(AW-1){1'b0}}, 1'b1};
			if (doRead)
				rdPtr <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + {{(AW-1){1'b0}}, 1'b1};
			count <= next_count;
			inReady <= (next_count != DEPTH);
			outValid <= (next_count != {(AW+1){1'b0}});
		end
	end

endmodule // ssfp_fifo

`default_nettype wire

/* hw/ssfp_framer.v */
// Purpose: Master framing engine of the synchronous serial port, three frame formats.
// Assumes: ref_clk at 100 MHz; serial clock derived by a divider, slave data is asynchronous.
// Notes: Format, polarity, phase and word size are latched at the start of each word; the divider is used live.
// Function
// - Words of 4 to 16 bits are supported in every format, and the slave uses the same length.
// - Each word leaves most significant bit first and least significant bit last.
// - The serial clock rests low whenever the port is idle.
// - The serial clock toggles only while a word is being moved.
// - A frame signal marks the start of each frame, and also its end in the SPI and command-response formats.
// - A driver enable output is high only while the port transmits.
// - In the pulsed format the frame signal pulses for one clock period from a rising edge.
// - In the pulsed format data changes on rising edges and is captured on falling edges.
// - In the SPI format the frame signal is an active-low select, low during the frame.
// - In the SPI format polarity and phase settings govern clock and frame behaviour.
// - Pulsed, SPI and command-response formats are selectable, one at a time.
`timescale 1ns/1ps
`default_nettype none
`include "ssfp_defs.vh"

module ssfp_framer (
	input wire ref_clk,
	input wire srst,
	input wire [1:0] frameFormat,
	input wire clockPolaritySel,
	input wire clockPhaseSel,
	input wire [3:0] wordSizeSel,
	input wire [7:0] clkHalfDiv,
	input wire [15:0] txData,
	input wire txValid,
	output wire txReady,
	output reg [15:0] rxData,
	output reg rxValid,
	output reg busy,
	output reg serialClockOut,
	output reg frameSyncOut,
	output reg serialDataOut,
	output reg lineDriverOe,
	input wire serialDataIn
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [3:0] clampSize;
		input [3:0] w;
		begin
			clampSize = (w < `SSFP_SIZE_MIN) ? `SSFP_SIZE_MIN : w;
		end
	endfunction

	function [15:0] wordMask;
		input [3:0] w;
		begin
			wordMask = 16'hFFFF >> (`SSFP_SIZE_MAX - w);
		end
	endfunction

	// Left-justify a right-justified word so bit 15 leaves first
	function [15:0] alignWord;
		input [15:0] d;
		input [3:0] w;
		begin
			alignWord = d << (`SSFP_SIZE_MAX - w);
		end
	endfunction

	// Clock level during the first half of each bit
	function clkLevelA;
		input [1:0] f;
		input p;
		input h;
		begin
			case (f)
				`SSFP_FMT_PULSED: clkLevelA = 1'b1;
				`SSFP_FMT_SPI: clkLevelA = h ? ~p : p;
				default: clkLevelA = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [2:0] state;
	reg [7:0] divCnt;
	reg [4:0] bitCnt;
	reg [15:0] txShift;
	reg [15:0] rxShift;
	reg [1:0] fmt;
	reg pol;
	reg pha;
	reg [3:0] wsel;
	reg respPhase;
	reg sdiMeta;
	reg sdiSync;
	wire [15:0] fifoData;
	wire fifoValid;
	wire tick;
	wire wordEnd;
	wire launchStart;
	wire [3:0] newSize;
	wire [15:0] alignedWord;
	wire [15:0] capturedWord;

	assign tick = (state != `SSFP_ST_IDLE) && (divCnt == clkHalfDiv);
	// Code 3 runs as command-response, so only the upper format bit is tested
	assign wordEnd = tick && (state == `SSFP_ST_BITB) && (bitCnt == 5'h00) &&
		!(fmt[1] && !respPhase);
	// Back-to-back pulsed words restart straight from the end of the previous one; other formats restart after its tail half period
	assign launchStart = fifoValid && ((state == `SSFP_ST_IDLE) ||
		(state == `SSFP_ST_TAIL && tick) || (wordEnd && fmt == `SSFP_FMT_PULSED));
	assign newSize = clampSize(wordSizeSel);
	assign alignedWord = alignWord(fifoData, newSize);
	assign capturedWord = rxShift & wordMask(wsel);

	ssfp_fifo #(
		.WIDTH(`SSFP_WORD_W),
		.DEPTH(`SSFP_FIFO_DEPTH),
		.AW(`SSFP_FIFO_AW)
	) txFifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.inData(txData),
		.inValid(txValid),
		.inReady(txReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(launchStart)
	);

	// ----------------------------------------
	// Slave data synchroniser
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			sdiMeta <= 1'b0;
			sdiSync <= 1'b0;
		end else begin
			sdiMeta <= serialDataIn;
			sdiSync <= sdiMeta;
		end
	end

	// ----------------------------------------
	// Framing engine
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			state <= `SSFP_ST_IDLE;
			divCnt <= 8'h00;
			bitCnt <= 5'h00;
			txShift <= 16'h0000;
			rxShift <= 16'h0000;
			fmt <= `SSFP_FMT_PULSED;
			pol <= 1'b0;
			pha <= 1'b0;
			wsel <= `SSFP_SIZE_MIN;
			respPhase <= 1'b0;
			rxData <= 16'h0000;
			rxValid <= 1'b0;
			busy <= 1'b0;
			serialClockOut <= 1'b0;
			frameSyncOut <= 1'b0;
			serialDataOut <= 1'b0;
			lineDriverOe <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if (wordEnd) begin
				rxData <= capturedWord;
				rxValid <= 1'b1;
			end
			// Divider only runs inside a transfer, so no edges appear between words
			if (launchStart || tick || state == `SSFP_ST_IDLE)
				divCnt <= 8'h00;
			else
				divCnt <= divCnt + 8'h01;
			if (launchStart) begin
				fmt <= frameFormat;
				pol <= clockPolaritySel;
				pha <= clockPhaseSel;
				wsel <= newSize;
				bitCnt <= {1'b0, newSize} + 5'h01;
				respPhase <= 1'b0;
				rxShift <= 16'h0000;
				busy <= 1'b1;
				lineDriverOe <= 1'b1;
				case (frameFormat)
					`SSFP_FMT_PULSED: begin
						state <= `SSFP_ST_FPA;
						serialClockOut <= 1'b1;
						frameSyncOut <= 1'b1;
						txShift <= alignedWord;
					end
					`SSFP_FMT_SPI: begin
						frameSyncOut <= 1'b0;
						serialClockOut <= clockPolaritySel;
						if (clockPhaseSel) begin
							state <= `SSFP_ST_LEAD;
							txShift <= alignedWord;
						end else begin
							state <= `SSFP_ST_BITA;
							serialDataOut <= alignedWord[15];
							txShift <= {alignedWord[14:0], 1'b0};
						end
					end
					default: begin
						state <= `SSFP_ST_BITA;
						frameSyncOut <= 1'b0;
						serialClockOut <= 1'b0;
						serialDataOut <= alignedWord[15];
						txShift <= {alignedWord[14:0], 1'b0};
					end
				endcase
			end else begin
				case (state)
					`SSFP_ST_IDLE: begin
						// Rests low in every format; SPI polarity only sets the in-frame level
						serialClockOut <= 1'b0;
						frameSyncOut <= (frameFormat != `SSFP_FMT_PULSED);
						lineDriverOe <= 1'b0;
						busy <= 1'b0;
					end
					`SSFP_ST_FPA: if (tick) begin
						state <= `SSFP_ST_FPB;
						serialClockOut <= 1'b0;
					end
					`SSFP_ST_FPB, `SSFP_ST_LEAD: if (tick) begin
						state <= `SSFP_ST_BITA;
						if (state == `SSFP_ST_FPB)
							frameSyncOut <= 1'b0;
						serialClockOut <= clkLevelA(fmt, pol, pha);
						serialDataOut <= txShift[15];
						txShift <= {txShift[14:0], 1'b0};
					end
					`SSFP_ST_BITA: if (tick) begin
						state <= `SSFP_ST_BITB;
						serialClockOut <= ~clkLevelA(fmt, pol, pha);
						rxShift <= {rxShift[14:0], sdiSync};
						bitCnt <= bitCnt - 5'h01;
					end
					`SSFP_ST_BITB: if (tick) begin
						if (bitCnt != 5'h00) begin
							state <= `SSFP_ST_BITA;
							serialClockOut <= clkLevelA(fmt, pol, pha);
							if (!respPhase) begin
								serialDataOut <= txShift[15];
								txShift <= {txShift[14:0], 1'b0};
							end
						end else if (fmt[1] && !respPhase) begin
							// One turnaround bit, then the response word
							respPhase <= 1'b1;
							lineDriverOe <= 1'b0;
							serialDataOut <= 1'b0;
							rxShift <= 16'h0000;
							bitCnt <= {1'b0, wsel} + 5'h02;
							state <= `SSFP_ST_BITA;
							serialClockOut <= 1'b0;
						end else if (fmt == `SSFP_FMT_PULSED) begin
							state <= `SSFP_ST_IDLE;
							serialClockOut <= 1'b0;
							lineDriverOe <= 1'b0;
						end else begin
							state <= `SSFP_ST_TAIL;
							// Drop the clock while the frame is still open, so idle sees no edge
							serialClockOut <= 1'b0;
						end
					end
					`SSFP_ST_TAIL: begin
						frameSyncOut <= 1'b1;
						if (tick)
							state <= `SSFP_ST_IDLE;
					end
					default: state <= `SSFP_ST_IDLE;
				endcase
			end
		end
	end

endmodule // ssfp_framer

`default_nettype wire

/* sim/ssfp_slave_model.sv */
// Purpose: Behavioural serial slave on the far side of the framing port.
// Assumes: Slave clock and frame are seen through ref_clk samples.
// Notes: Off-frame the data line toggles every cycle, as nothing drives it.
`timescale 1ns/1ps
`default_nettype none
module ssfp_slave_model (
	input wire logic ref_clk,
	input wire logic sclk,
	input wire logic frm,
	input wire logic sdo,
	input wire logic [1:0] fmt,
	input wire logic pol,
	input wire logic pha,
	input wire logic [15:0] resp,
	input wire logic [4:0] nBits,
	output logic sdi,
	output logic [15:0] cap
);
	// ----------------------------------------
	// Shift logic
	// ----------------------------------------
	logic act, run, frmQ, sclkQ, tog, launch, start, capEdge;
	logic [4:0] idx;
	initial begin
		run = 1'b0;
		frmQ = 1'b0;
		sclkQ = 1'b0;
		tog = 1'b0;
		idx = 5'h00;
		cap = 16'h0000;
	end
	// Pulsed frame is only a marker; the slave stays active until its last bit is taken
	assign act = (fmt == 2'h0) ? run : !frm;
	assign start = (fmt == 2'h0) ? (frm && !frmQ) : (!frm && frmQ);
	assign launch = (sclk != sclkQ) && (sclk == ((fmt == 2'h0) ? 1'b1 : (pha ? !pol : pol)));
	assign capEdge = (sclk != sclkQ) && !launch;
	// Response MSB first, constant ones in command-response
	assign sdi = act ? ((fmt == 2'h2) ? 1'b1 : resp[idx[3:0]]) : tog;
	always @(posedge ref_clk) begin
		frmQ <= frm;
		sclkQ <= sclk;
		tog <= !tog;
		// Same word length as the port; pulsed drives on rise, captures on fall
		if (start) begin
			idx <= (fmt == 2'h1 && !pha) ? nBits - 5'h1 : nBits;
			run <= 1'b1;
		end else begin
			if (launch)
				idx <= idx - 5'h1;
			if (fmt == 2'h0 && capEdge && idx == 5'h00)
				run <= 1'b0;
		end
		if (act && capEdge)
			cap <= {cap[14:0], sdo};
	end
endmodule // ssfp_slave_model
`default_nettype wire

/* sim/ssfp_framer_chk.sv */
// Purpose: Port checker of the framing engine.
// Assumes: Bound to ssfp_framer; single clock domain.
// Notes: Idle checks wait until the port has settled after reset.
`timescale 1ns/1ps
`default_nettype none
module ssfp_framer_chk (
	input wire ref_clk,
	input wire srst,
	input wire [1:0] frameFormat,
	input wire clockPolaritySel,
	input wire [7:0] clkHalfDiv,
	input wire busy,
	input wire serialClockOut,
	input wire frameSyncOut,
	input wire serialDataOut,
	input wire lineDriverOe,
	input wire rxValid
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	logic [1:0] age;
	logic [9:0] frmRun;
	wire ok = age == 2'h3;
	wire pf = frameFormat == 2'h0;
	wire sf = frameFormat == 2'h1;
	always @(posedge ref_clk) age <= srst ? 2'h0 : (ok ? age : age + 2'h1);
	// Cycles the frame signal has stood high, to time the pulse
	always @(posedge ref_clk) frmRun <= (srst || !frameSyncOut) ? 10'h000 : frmRun + 10'h001;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	AST_IDLE_LOW: assert property (ok && !busy && !$past(busy) |-> !serialClockOut)
		else $error("clk high idle");
	AST_QUIET: assert property (ok && !busy && !$past(busy) |-> $stable(serialClockOut))
		else $error("clk edge idle");
	AST_OE: assert property (lineDriverOe |-> busy) else $error("oe while idle");
	AST_RX_END: assert property (rxValid && !pf |-> ##[0:300] frameSyncOut) else $error("no end");
	AST_PULSE_LEN: assert property (pf && $fell(frameSyncOut) |-> frmRun == {1'b0, clkHalfDiv, 1'b0} + 10'h002)
		else $error("pulse not one period");
	AST_PULSE_RISE: assert property (pf && $rose(frameSyncOut) |-> $rose(serialClockOut))
		else $error("pulse not at rise");
	AST_PULSE_IDLE: assert property (ok && pf && $past(pf) && !busy |-> !frameSyncOut)
		else $error("pulse frame idle");
	AST_PULSE_DATA: assert property (pf && busy && $past(busy) && $changed(serialDataOut)
		|-> $rose(serialClockOut)) else $error("data off rise");
	AST_SPI_SEL: assert property (sf && busy && $changed(serialClockOut) |-> !frameSyncOut)
		else $error("select high");
	AST_SPI_LEAD: assert property (sf && $fell(frameSyncOut) |-> serialClockOut == clockPolaritySel)
		else $error("lead level");
	COV_PULSED: cover property (rxValid && pf);
	COV_SPI: cover property (rxValid && sf);
	COV_CMD: cover property (rxValid && frameFormat == 2'h2);
endmodule // ssfp_framer_chk
bind ssfp_framer ssfp_framer_chk CHK (.ref_clk(ref_clk), .srst(srst), .frameFormat(frameFormat),
	.clockPolaritySel(clockPolaritySel), .clkHalfDiv(clkHalfDiv), .busy(busy),
	.serialClockOut(serialClockOut),
	.frameSyncOut(frameSyncOut), .serialDataOut(serialDataOut),
	.lineDriverOe(lineDriverOe), .rxValid(rxValid));
`default_nettype wire

/* sim/ssfp_framer_bench.sv */
// Purpose: Self-checking bench of the framing engine with a slave model.
// Assumes: Serial half period of 8 cycles gives a 160 ns serial clock.
// Notes: Command-response slave answers all ones, so only the length is judged.
`timescale 1ns/1ps
`default_nettype none
module ssfp_framer_bench;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	logic refClk, srst, cpol, cpha, txValid, sdi;
	logic [1:0] fmt;
	logic [3:0] wsz;
	logic [15:0] txData, rs, cap;
	wire [15:0] rxData;
	wire txReady, rxValid, busy, sclk, frm, sdo, oe;
	int n_fail, compares, cyc;
	ssfp_framer DUT (.ref_clk(refClk), .srst(srst), .frameFormat(fmt), .clockPolaritySel(cpol),
		.clockPhaseSel(cpha), .wordSizeSel(wsz), .clkHalfDiv(8'h07), .txData(txData),
		.txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .busy(busy),
		.serialClockOut(sclk), .frameSyncOut(frm), .serialDataOut(sdo), .lineDriverOe(oe),
		.serialDataIn(sdi));
	ssfp_slave_model SLV (.ref_clk(refClk), .sclk(sclk), .frm(frm), .sdo(sdo), .fmt(fmt),
		.pol(cpol), .pha(cpha), .resp(rs), .nBits({1'b0, wsz} + 5'h1), .sdi(sdi), .cap(cap));
	initial begin
		refClk = 1'b0;
		forever #5 refClk = !refClk;
	end
	// Long enough for every scenario with a wide margin
	always @(posedge refClk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			print_verdict();
		end
	end
	task print_verdict;
		$display("mismatches %0d of %0d compares", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cfg(input logic [1:0] f, input logic p, input logic h, input logic [3:0] w,
		input logic [15:0] r);
		@(posedge refClk);
		#1;
		fmt = f;
		cpol = p;
		cpha = h;
		wsz = w;
		rs = r;
	endtask
	task push(input logic [15:0] d);
		@(posedge refClk);
		#1;
		txData = d;
		txValid = 1'b1;
		@(posedge refClk);
		while (txReady !== 1'b1) @(posedge refClk);
		#1 txValid = 1'b0;
	endtask
	task get(input logic [3:0] w, input logic [15:0] d);
		logic [15:0] m;
		m = 16'hFFFF >> (4'hF - w);
		@(posedge refClk);
		while (rxValid !== 1'b1) @(posedge refClk);
		chk(rxData, (fmt == 2'h2) ? m : rs & m);
		if (fmt != 2'h2) chk(cap & m, d & m);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_pulsed;
		cfg(2'h0, 1'b0, 1'b0, 4'h3, 16'h000A);
		push(16'h0005);
		push(16'h000C);
		get(4'h3, 16'h0005);
		get(4'h3, 16'h000C);
	endtask
	task t_spi_modes;
		for (int i = 0; i < 4; i++) begin
			cfg(2'h1, i[1], i[0], 4'h7, 16'h00C3);
			push(16'h005A);
			get(4'h7, 16'h005A);
		end
	endtask
	task t_spi16;
		cfg(2'h1, 1'b0, 1'b0, 4'hF, 16'h8001);
		push(16'hF00F);
		get(4'hF, 16'hF00F);
	endtask
	task t_cmd;
		cfg(2'h2, 1'b0, 1'b0, 4'h4, 16'h0000);
		push(16'h0013);
		get(4'h4, 16'h0013);
	endtask
	task t_full;
		int acc;
		acc = 0;
		cfg(2'h1, 1'b0, 1'b0, 4'h3, 16'h0006);
		txData = 16'h0009;
		txValid = 1'b1;
		repeat (14) begin
			@(posedge refClk);
			if (txReady === 1'b1) acc++;
		end
		#1 txValid = 1'b0;
		chk(16'(acc >= 8 && acc <= 10), 16'h0001);
		repeat (acc) get(4'h3, 16'h0009);
	endtask
	initial begin
		n_fail = 0;
		compares = 0;
		cyc = 0;
		srst = 1'b1;
		{fmt, cpol, cpha, wsz, txData, txValid, rs} = '0;
		repeat (6) @(posedge refClk);
		#1 srst = 1'b0;
		repeat (3) @(posedge refClk);
		t_pulsed();
		t_spi_modes();
		t_spi16();
		t_cmd();
		t_full();
		repeat (20) @(posedge refClk);
		print_verdict();
	end
endmodule // ssfp_framer_bench
`default_nettype wire
